// >>> core/hsps_params.svh
// Constants of the host slave port: widths, timing, register map
`ifndef HSPS_PARAMS_SVH
`define HSPS_PARAMS_SVH

`define HSPS_ID_W 4
`define HSPS_ADDR_HI 29
`define HSPS_ADDR_LO 7
`define HSPS_ADDR_W 23
`define HSPS_DATA_W 64
`define HSPS_LANES 8
`define HSPS_MEM_WORDS 16
`define HSPS_IDX_HI 10
`define HSPS_IDX_LO 7

`define HSPS_SYS_NS 8
`define HSPS_LINK_NS 48
`define HSPS_DIV_HALF (`HSPS_LINK_NS / (2 * `HSPS_SYS_NS))

`define HSPS_AVS_AW 6
`define HSPS_REG_CTRL 6'h00
`define HSPS_REG_TGT 6'h04
`define HSPS_REG_ADDR 6'h08
`define HSPS_REG_BE 6'h0c
`define HSPS_REG_WLO 6'h10
`define HSPS_REG_WHI 6'h14
`define HSPS_REG_RLO 6'h18
`define HSPS_REG_RHI 6'h1c
`define HSPS_REG_STAT 6'h20
`define HSPS_REG_MODE 6'h24
`define HSPS_REG_BURST 6'h28

`define HSPS_CTRL_GO 0
`define HSPS_CTRL_RD 1
`define HSPS_CTRL_BC 2
`define HSPS_MODE_SYNC 0
`define HSPS_MODE_DUAL 1
`define HSPS_MODE_DST_LO 2

`endif

// >>> core/hsps_pkg.sv
// Types shared by both ends of the host slave port
`include "hsps_params.svh"
`default_nettype none
package hsps_pkg;
  typedef enum logic [1:0] {
    HSPS_IDLE = 2'b00,
    HSPS_ACT = 2'b01,
    HSPS_ACK = 2'b11,
    HSPS_REL = 2'b10
  } hsps_dev_st_t;

  typedef enum logic [2:0] {
    HSPS_H_IDLE = 3'b000,
    HSPS_H_SETUP = 3'b001,
    HSPS_H_STRB = 3'b011,
    HSPS_H_DONE = 3'b010,
    HSPS_H_WREL = 3'b110
  } hsps_host_st_t;

  typedef struct packed {
    hsps_dev_st_t st;
    logic strap_done;
    logic sync_mode;
    logic wide;
    logic dual;
    logic le;
    logic [3:0] idx;
    logic wr;
    logic burst;
    logic [`HSPS_LANES-1:0] be;
    logic ack_n;
    logic ack_oe;
    logic [`HSPS_DATA_W-1:0] dout;
    logic [`HSPS_LANES-1:0] doe;
    logic [`HSPS_DATA_W-1:0] user_word;
    logic [`HSPS_MEM_WORDS-1:0][`HSPS_DATA_W-1:0] mem;
  } hsps_dev_t;

  typedef struct packed {
    hsps_host_st_t st;
    logic busy;
    logic done;
    logic go;
    logic rd;
    logic bc;
    logic [`HSPS_ID_W-1:0] tgt;
    logic [`HSPS_ADDR_W-1:0] addr;
    logic [`HSPS_LANES-1:0] be;
    logic [`HSPS_DATA_W-1:0] wdata;
    logic [`HSPS_DATA_W-1:0] rdata;
    logic [3:0] mode;
    logic [7:0] beats;
    logic [7:0] left;
    logic [1:0] div;
    logic clk;
    logic ack_prev;
    logic psel_n;
    logic bsel_n;
    logic [`HSPS_LANES-1:0] wbs;
    logic [`HSPS_LANES-1:0] dbs;
    logic [`HSPS_LANES-1:0] wbe;
    logic [`HSPS_LANES-1:0] dbe;
    logic rds;
    logic rw;
    logic rde;
    logic brst;
    logic [`HSPS_LANES-1:0] lane_oe;
    logic [31:0] rdq;
    logic wreq;
  } hsps_host_t;
endpackage
`default_nettype wire

// >>> core/hsps_if.sv
// Pin bundle between host end and device end of the port
`include "hsps_params.svh"
`default_nettype none
interface hsps_if;
  logic port_clock_in;
  logic port_select_n;
  logic broadcast_select_n;
  logic [`HSPS_ID_W-1:0] port_identity_in;
  logic [`HSPS_ADDR_HI:`HSPS_ADDR_LO] port_address;
  logic [`HSPS_LANES-1:0] async_write_byte_strobes;
  logic [`HSPS_LANES-1:0] async_data_byte_strobes;
  logic [`HSPS_LANES-1:0] sync_write_byte_enables;
  logic [`HSPS_LANES-1:0] sync_data_byte_enables;
  logic async_read_strobe;
  logic read_write_select;
  logic sync_read_enable;
  logic burst_indicate;
  logic [1:0] data_structure_sel;
  logic [`HSPS_DATA_W-1:0] host_data_o;
  logic [`HSPS_LANES-1:0] host_data_oe;
  logic [`HSPS_DATA_W-1:0] dev_data_o;
  logic [`HSPS_LANES-1:0] dev_data_oe;
  logic ack_o;
  logic ack_oe;
  wire logic [`HSPS_DATA_W-1:0] port_data;
  wire logic transfer_ack_n;

  for (genvar g = 0; g < `HSPS_LANES; g++) begin : g_lane
    assign port_data[8*g+:8] = dev_data_oe[g] ? dev_data_o[8*g+:8] :
      host_data_oe[g] ? host_data_o[8*g+:8] : 8'hff;
  end
  // Pull-ups on the data lanes and the acknowledge line
  assign transfer_ack_n = ack_oe ? ack_o : 1'b1;

  modport host (
    output port_clock_in, port_select_n, broadcast_select_n, port_identity_in,
    output port_address, async_write_byte_strobes, async_data_byte_strobes,
    output sync_write_byte_enables, sync_data_byte_enables, async_read_strobe,
    output read_write_select, sync_read_enable, burst_indicate, data_structure_sel,
    output host_data_o, host_data_oe,
    input port_data, transfer_ack_n
  );
  modport dev (
    input port_clock_in, port_select_n, broadcast_select_n, port_identity_in,
    input port_address, async_write_byte_strobes, async_data_byte_strobes,
    input sync_write_byte_enables, sync_data_byte_enables, async_read_strobe,
    input read_write_select, sync_read_enable, burst_indicate, data_structure_sel,
    input port_data,
    output dev_data_o, dev_data_oe, ack_o, ack_oe
  );
endinterface
`default_nettype wire

// >>> core/hsps_sync2.sv
// Two-flop synchroniser for a bundle of levels
`default_nettype none
module hsps_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic [W-1:0] d, // Foreign levels
  output logic [W-1:0] q // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hsps_sync_t;
  hsps_sync_t r_q;
  hsps_sync_t r_d;

  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_q <= {RST, RST};
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule
`default_nettype wire

// >>> core/hsps_device.sv
// Device end of the host slave port: selection, strobe decode, ack, memory
`include "hsps_params.svh"
`default_nettype none
// Summary of operation
// - Respond on identity match or broadcast
// - Broadcast select lets one write reach many
// - Read ack marks driven data valid
// - Write ack only after data captured
// - Async dual: byte write strobes, read strobe
// - Async single: byte strobes plus direction
// - Sync dual: write enables, read enable
// - Sync single: byte enables plus direction
// - Burst honoured only in synchronous mode
// - Structure select shapes little-endian accesses
// - Sync transactions timed by host clock
// - Host address selects internal location
// - Sync mode strap caught at reset release
// - Bus width strap caught at reset release
module hsps_device (
  hsps_if.dev lk, // Pins toward the host
  input wire logic power_on_reset_n, // Sync reset on link clock
  input wire logic [`HSPS_ID_W-1:0] configured_port_identity, // Own identity
  input wire logic sync_mode_strap, // Synchronous operation
  input wire logic wide_bus_strap, // 64-bit data bus
  input wire logic dual_strobe_strap, // Dual strobe mode
  input wire logic little_endian_strap, // Little-endian mode
  input wire logic [3:0] user_index, // Internal word to view
  output logic [`HSPS_DATA_W-1:0] user_word // Viewed word
);
  localparam int unsigned ASYNC_W = 24;
  localparam logic [ASYNC_W-1:0] ASYNC_RST = 24'hc00000;

  hsps_pkg::hsps_dev_t q;
  hsps_pkg::hsps_dev_t d;
  logic [ASYNC_W-1:0] async_raw;
  logic [ASYNC_W-1:0] async_s;
  logic psel_n;
  logic bsel_n;
  logic rw;
  logic rd_req;
  logic sel;
  logic any;
  logic [`HSPS_ID_W-1:0] id;
  logic [`HSPS_LANES-1:0] be;
  logic [2:0] k;
  logic [3:0] nidx;
  logic [3:0] strap_raw;
  logic [3:0] strap_s;

  assign async_raw = {lk.port_select_n, lk.broadcast_select_n, lk.port_identity_in,
    lk.async_write_byte_strobes, lk.async_data_byte_strobes,
    lk.async_read_strobe, lk.read_write_select};

  assign strap_raw = {little_endian_strap, dual_strobe_strap, wide_bus_strap, sync_mode_strap};

  // Strap flops run through reset, so the level is settled at release
  hsps_sync2 #(
    .W(4),
    .RST(4'h0)
  ) u_strap_sync (
    .clk(lk.port_clock_in),
    .rst_n(1'b1),
    .d(strap_raw),
    .q(strap_s)
  );

  // Address, data and structure pins only matter once the strobes are through;
  // the host holds them steady from select until the ack is released
  // Async pins are not tied to the link clock
  hsps_sync2 #(
    .W(ASYNC_W),
    .RST(ASYNC_RST)
  ) u_async_sync (
    .clk(lk.port_clock_in),
    .rst_n(power_on_reset_n),
    .d(async_raw),
    .q(async_s)
  );

  always_comb begin
    d = q;
    if (q.sync_mode) begin
      psel_n = lk.port_select_n;
      bsel_n = lk.broadcast_select_n;
      id = lk.port_identity_in;
      rw = lk.read_write_select;
      if (q.dual) begin
        be = lk.sync_write_byte_enables;
        rd_req = lk.sync_read_enable;
      end else begin
        be = rw ? 8'h00 : lk.sync_data_byte_enables;
        rd_req = rw & (|lk.sync_data_byte_enables);
      end
    end else begin
      psel_n = async_s[23];
      bsel_n = async_s[22];
      id = async_s[21:18];
      rw = async_s[0];
      if (q.dual) begin
        be = async_s[17:10];
        rd_req = async_s[1];
      end else begin
        be = rw ? 8'h00 : async_s[9:2];
        rd_req = rw & (|async_s[9:2]);
      end
    end
    // Narrow bus ignores the upper lanes
    if (!q.wide) begin
      be[7:4] = 4'h0;
    end
    sel = (!psel_n && id == configured_port_identity) || !bsel_n;
    any = sel && (rd_req || (|be));

    k = 3'h0;
    if (q.le) begin
      case (lk.data_structure_sel)
        2'h1: k = 3'h1;
        2'h2: k = 3'h3;
        2'h3: k = 3'h7;
        default: k = 3'h0;
      endcase
    end
    nidx = q.idx + 4'h1;

    // Straps are taken once, at the first edge after reset release
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.sync_mode = strap_s[0];
      d.wide = strap_s[1];
      d.dual = strap_s[2];
      d.le = strap_s[3];
    end

    case (q.st)
      hsps_pkg::HSPS_IDLE: begin
        d.ack_oe = 1'b0;
        d.doe = 8'h00;
        if (q.strap_done && any) begin
          d.idx = lk.port_address[`HSPS_IDX_HI:`HSPS_IDX_LO];
          d.wr = |be;
          d.be = be;
          d.burst = q.sync_mode && lk.burst_indicate;
          d.st = hsps_pkg::HSPS_ACT;
        end
      end
      hsps_pkg::HSPS_ACT: begin
        if (q.wr) begin
          for (int i = 0; i < `HSPS_LANES; i++) begin
            if (q.be[i]) begin
              d.mem[q.idx][8*(i^k)+:8] = lk.port_data[8*i+:8];
            end
          end
        end else begin
          for (int i = 0; i < `HSPS_LANES; i++) begin
            d.dout[8*i+:8] = q.mem[q.idx][8*(i^k)+:8];
          end
          d.doe = q.wide ? 8'hff : 8'h0f;
        end
        // Ack falls with the stored word or the driven data
        d.ack_n = 1'b0;
        d.ack_oe = 1'b1;
        d.st = hsps_pkg::HSPS_ACK;
      end
      hsps_pkg::HSPS_ACK: begin
        // A burst beat lasts one cycle; otherwise wait for strobe release
        if (q.burst || !any) begin
          d.ack_n = 1'b1;
          d.doe = 8'h00;
          d.st = hsps_pkg::HSPS_REL;
        end
      end
      hsps_pkg::HSPS_REL: begin
        if (q.burst && any && (q.wr == (|be))) begin
          d.idx = nidx;
          d.be = be;
          d.st = hsps_pkg::HSPS_ACT;
        end else begin
          // Ack was driven high for a cycle before letting go
          d.ack_oe = 1'b0;
          d.st = hsps_pkg::HSPS_IDLE;
        end
      end
      default: begin
        d.ack_oe = 1'b0;
        d.doe = 8'h00;
        d.st = hsps_pkg::HSPS_IDLE;
      end
    endcase

    d.user_word = q.mem[user_index];
  end

  always_ff @(posedge lk.port_clock_in) begin
    if (!power_on_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lk.dev_data_o = q.dout;
  assign lk.dev_data_oe = q.doe;
  assign lk.ack_o = q.ack_n;
  assign lk.ack_oe = q.ack_oe;
  assign user_word = q.user_word;
endmodule
`default_nettype wire

// >>> core/hsps_host.sv
// Host end: Avalon-MM command registers driving the port pins
//
// Register access over Avalon-MM and the register offsets were decided locally.
`include "hsps_params.svh"
`default_nettype none
module hsps_host (
  hsps_if.host lk, // Pins toward the device
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic [`HSPS_AVS_AW-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest // Stall
);
  hsps_pkg::hsps_host_t q;
  hsps_pkg::hsps_host_t d;
  logic ack_s;
  logic [`HSPS_DATA_W-1:0] data_s;
  logic upd;
  logic fall;
  logic [31:0] rmux;

  hsps_sync2 #(.W(1), .RST(1'b1)) u_ack_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(lk.transfer_ack_n),
    .q(ack_s)
  );
  hsps_sync2 #(.W(`HSPS_DATA_W), .RST('0)) u_data_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(lk.port_data),
    .q(data_s)
  );

  always_comb begin
    d = q;
    case (avs_address)
      `HSPS_REG_CTRL: rmux = {29'h0, q.bc, q.rd, 1'b0};
      `HSPS_REG_TGT: rmux = {28'h0, q.tgt};
      `HSPS_REG_ADDR: rmux = {9'h0, q.addr};
      `HSPS_REG_BE: rmux = {24'h0, q.be};
      `HSPS_REG_WLO: rmux = q.wdata[31:0];
      `HSPS_REG_WHI: rmux = q.wdata[63:32];
      `HSPS_REG_RLO: rmux = q.rdata[31:0];
      `HSPS_REG_RHI: rmux = q.rdata[63:32];
      `HSPS_REG_STAT: rmux = {30'h0, q.done, q.busy};
      `HSPS_REG_MODE: rmux = {28'h0, q.mode};
      `HSPS_REG_BURST: rmux = {24'h0, q.beats};
      default: rmux = 32'h0;
    endcase
    // Answer one cycle after the request; write lands at the release edge
    d.wreq = 1'b1;
    if ((avs_read || avs_write) && q.wreq) begin
      d.wreq = 1'b0;
      d.rdq = rmux;
    end
    if (avs_write && !q.wreq && !q.busy) begin
      case (avs_address)
        `HSPS_REG_CTRL: begin
          if (avs_writedata[`HSPS_CTRL_GO]) begin
            d.go = 1'b1;
            d.busy = 1'b1;
            d.done = 1'b0;
            d.rd = avs_writedata[`HSPS_CTRL_RD];
            d.bc = avs_writedata[`HSPS_CTRL_BC];
            d.left = q.beats;
          end
        end
        `HSPS_REG_TGT: d.tgt = avs_writedata[`HSPS_ID_W-1:0];
        `HSPS_REG_ADDR: d.addr = avs_writedata[`HSPS_ADDR_W-1:0];
        `HSPS_REG_BE: d.be = avs_writedata[7:0];
        `HSPS_REG_WLO: d.wdata[31:0] = avs_writedata;
        `HSPS_REG_WHI: d.wdata[63:32] = avs_writedata;
        `HSPS_REG_MODE: d.mode = avs_writedata[3:0];
        `HSPS_REG_BURST: d.beats = avs_writedata[7:0];
        default: d.tgt = q.tgt;
      endcase
    end

    // Link clock from sys_clk; pins change as it falls
    upd = 1'b0;
    if (q.div == 2'(`HSPS_DIV_HALF - 1)) begin
      d.div = 2'h0;
      d.clk = !q.clk;
      upd = q.clk;
    end else begin
      d.div = q.div + 2'h1;
    end

    d.ack_prev = ack_s;
    fall = q.ack_prev && !ack_s;
    case (q.st)
      hsps_pkg::HSPS_H_IDLE: begin
        if (q.go && upd) begin
          d.go = 1'b0;
          d.psel_n = q.bc;
          d.bsel_n = !q.bc;
          d.rw = q.rd;
          d.brst = q.mode[`HSPS_MODE_SYNC] && q.beats > 8'h1;
          d.lane_oe = q.rd ? 8'h00 : 8'hff;
          d.st = hsps_pkg::HSPS_H_SETUP;
        end
      end
      hsps_pkg::HSPS_H_SETUP: begin
        if (upd) begin
          case ({q.mode[`HSPS_MODE_SYNC], q.mode[`HSPS_MODE_DUAL]})
            2'b01: begin
              d.rds = q.rd;
              d.wbs = q.rd ? 8'h00 : q.be;
            end
            2'b00: d.dbs = q.be;
            2'b11: begin
              d.rde = q.rd;
              d.wbe = q.rd ? 8'h00 : q.be;
            end
            default: d.dbe = q.be;
          endcase
          d.st = hsps_pkg::HSPS_H_STRB;
        end
      end
      hsps_pkg::HSPS_H_STRB: begin
        if (fall) begin
          if (q.rd) begin
            d.rdata = data_s;
          end
          if (q.brst && q.left > 8'h1) begin
            d.left = q.left - 8'h1;
          end else begin
            d.st = hsps_pkg::HSPS_H_DONE;
          end
        end
      end
      hsps_pkg::HSPS_H_DONE: begin
        if (upd) begin
          d.wbs = 8'h00;
          d.dbs = 8'h00;
          d.wbe = 8'h00;
          d.dbe = 8'h00;
          d.rds = 1'b0;
          d.rde = 1'b0;
          d.st = hsps_pkg::HSPS_H_WREL;
        end
      end
      hsps_pkg::HSPS_H_WREL: begin
        if (upd && ack_s) begin
          d.psel_n = 1'b1;
          d.bsel_n = 1'b1;
          d.lane_oe = 8'h00;
          d.brst = 1'b0;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = hsps_pkg::HSPS_H_IDLE;
        end
      end
      default: d.st = hsps_pkg::HSPS_H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.wreq <= 1'b1;
      q.psel_n <= 1'b1;
      q.bsel_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign lk.port_clock_in = q.clk;
  assign lk.port_select_n = q.psel_n;
  assign lk.broadcast_select_n = q.bsel_n;
  assign lk.port_identity_in = q.tgt;
  assign lk.port_address = q.addr;
  assign lk.async_write_byte_strobes = q.wbs;
  assign lk.async_data_byte_strobes = q.dbs;
  assign lk.sync_write_byte_enables = q.wbe;
  assign lk.sync_data_byte_enables = q.dbe;
  assign lk.async_read_strobe = q.rds;
  assign lk.read_write_select = q.rw;
  assign lk.sync_read_enable = q.rde;
  assign lk.burst_indicate = q.brst;
  assign lk.data_structure_sel = q.mode[`HSPS_MODE_DST_LO+1:`HSPS_MODE_DST_LO];
  assign lk.host_data_o = q.wdata;
  assign lk.host_data_oe = q.lane_oe;
  assign avs_readdata = q.rdq;
  assign avs_waitrequest = q.wreq;
endmodule
`default_nettype wire

// >>> verif/hsps_asserts.sv
// Link-side checker for the host slave port pins
`default_nettype none
module hsps_asserts (
  input wire logic port_clock_in, // Link clock
  input wire logic power_on_reset_n, // Device reset
  input wire logic [3:0] configured_port_identity, // Own identity
  input wire logic wide_bus_strap, // Bus width strap
  input wire logic port_select_n, // Select
  input wire logic broadcast_select_n, // Broadcast select
  input wire logic [3:0] port_identity_in, // Identity lines
  input wire logic [7:0] async_write_byte_strobes, // Async write strobes
  input wire logic [7:0] async_data_byte_strobes, // Async data strobes
  input wire logic [7:0] sync_write_byte_enables, // Sync write enables
  input wire logic [7:0] sync_data_byte_enables, // Sync data enables
  input wire logic async_read_strobe, // Async read strobe
  input wire logic read_write_select, // Direction
  input wire logic sync_read_enable, // Sync read enable
  input wire logic transfer_ack_n, // Resolved ack
  input wire logic ack_oe, // Ack drive
  input wire logic [7:0] dev_data_oe // Data drive
);
  logic sel;
  logic req;
  logic rdq;
  assign sel = (!port_select_n && port_identity_in == configured_port_identity) ||
    !broadcast_select_n;
  assign req = |{async_write_byte_strobes, async_data_byte_strobes, sync_write_byte_enables,
    sync_data_byte_enables, async_read_strobe, sync_read_enable};
  assign rdq = async_read_strobe || sync_read_enable ||
    (read_write_select && |{async_data_byte_strobes, sync_data_byte_enables});

  default clocking cb @(posedge port_clock_in);
  endclocking
  default disable iff (!power_on_reset_n);

  // Async path adds two flops, so the bound covers both modes
  a_match_answers: assert property (!port_select_n && port_identity_in ==
    configured_port_identity && $rose(req) |-> ##[1:12] !transfer_ack_n)
    else $error("matched request not acknowledged");
  a_bcast_answers: assert property (!broadcast_select_n && $rose(req) |->
    ##[1:12] !transfer_ack_n)
    else $error("broadcast request not acknowledged");
  a_read_drives: assert property (!transfer_ack_n && rdq |-> dev_data_oe != 8'h00)
    else $error("read acknowledged without data driven");
  a_ack_after_req: assert property ($fell(transfer_ack_n) |->
    $past(req, 2) && $past(sel, 2))
    else $error("ack fell without a held request");
  a_ack_bounded: assert property ($fell(transfer_ack_n) |-> ##[1:16] transfer_ack_n)
    else $error("ack stuck low");
  a_unsel_quiet: assert property (!sel [*5] |-> !ack_oe && dev_data_oe == 8'h00)
    else $error("unselected port drives pins");
  a_data_with_ack: assert property (dev_data_oe != 8'h00 |-> ack_oe)
    else $error("data driven without ack drive");
  a_narrow_lanes: assert property (!wide_bus_strap |-> dev_data_oe[7:4] == 4'h0)
    else $error("upper lanes driven on narrow bus");

  cover property (!broadcast_select_n && !transfer_ack_n);
  cover property (async_read_strobe && !transfer_ack_n);
  cover property (sync_read_enable && !transfer_ack_n);
endmodule
`default_nettype wire

// >>> verif/hsps_bench.sv
// Testbench joining host end and device end of the port
`include "hsps_params.svh"
`default_nettype none
module hsps_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] OWN_ID = 4'h5;
  localparam logic [63:0] LANES = 64'h0706050403020100;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic power_on_reset_n = 1'b0;
  logic [3:0] straps = 4'h0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] user_index = 4'h0;
  logic [63:0] user_word;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;

  hsps_if lk_if ();
  hsps_host hsps_host_inst (.lk(lk_if), .sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // Straps: bit0 sync, bit1 dual, bit2 wide, bit3 little-endian
  hsps_device hsps_device_inst (.lk(lk_if), .power_on_reset_n(power_on_reset_n),
    .configured_port_identity(OWN_ID), .sync_mode_strap(straps[0]),
    .wide_bus_strap(straps[2]), .dual_strobe_strap(straps[1]),
    .little_endian_strap(straps[3]), .user_index(user_index), .user_word(user_word));
  hsps_asserts hsps_asserts_inst (.port_clock_in(lk_if.port_clock_in),
    .power_on_reset_n(power_on_reset_n), .configured_port_identity(OWN_ID),
    .wide_bus_strap(straps[2]), .port_select_n(lk_if.port_select_n),
    .broadcast_select_n(lk_if.broadcast_select_n), .port_identity_in(lk_if.port_identity_in),
    .async_write_byte_strobes(lk_if.async_write_byte_strobes),
    .async_data_byte_strobes(lk_if.async_data_byte_strobes),
    .sync_write_byte_enables(lk_if.sync_write_byte_enables),
    .sync_data_byte_enables(lk_if.sync_data_byte_enables),
    .async_read_strobe(lk_if.async_read_strobe), .read_write_select(lk_if.read_write_select),
    .sync_read_enable(lk_if.sync_read_enable), .transfer_ack_n(lk_if.transfer_ack_n),
    .ack_oe(lk_if.ack_oe), .dev_data_oe(lk_if.dev_data_oe));

  always #4 sys_clk = ~sys_clk;

  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Covers every test with margin; a hung handshake lands here
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      finish_test();
    end
  end

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task av(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask

  task op(input logic [3:0] tgt, input logic [3:0] idx, input logic [7:0] be,
    input logic [63:0] wd, input logic [2:0] ctl, input logic [7:0] beats,
    output logic [63:0] rd);
    logic [31:0] s;
    logic [31:0] lo;
    wr(`HSPS_REG_TGT, {28'h0, tgt});
    wr(`HSPS_REG_ADDR, {28'h0, idx});
    wr(`HSPS_REG_BE, {24'h0, be});
    wr(`HSPS_REG_WLO, wd[31:0]);
    wr(`HSPS_REG_WHI, wd[63:32]);
    wr(`HSPS_REG_BURST, {24'h0, beats});
    wr(`HSPS_REG_CTRL, {29'h0, ctl});
    s = 32'h0;
    while (s[1:0] !== 2'b10) av(1'b0, `HSPS_REG_STAT, 32'h0, s);
    av(1'b0, `HSPS_REG_RLO, 32'h0, lo);
    av(1'b0, `HSPS_REG_RHI, 32'h0, s);
    rd = {s, lo};
  endtask

  task peek(input logic [3:0] idx, input logic [63:0] exp);
    user_index <= idx;
    repeat (30) @(posedge sys_clk);
    chk("user_word", user_word, exp);
  endtask

  task dev_reset(input logic [3:0] s);
    power_on_reset_n <= 1'b0;
    straps <= s;
    repeat (60) @(posedge sys_clk);
    power_on_reset_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
  endtask

  function automatic logic [63:0] swap(input logic [63:0] w, input logic [1:0] k);
    logic [63:0] r;
    int x;
    x = (k == 2'd0) ? 0 : (k == 2'd1) ? 1 : (k == 2'd2) ? 3 : 7;
    for (int j = 0; j < 8; j++) begin
      r[8*j+:8] = w[8*(j^x)+:8];
    end
    return r;
  endfunction

  initial begin
    logic [63:0] a;
    logic [63:0] d;
    logic [31:0] s;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    dev_reset(4'b0100);
    av(1'b0, `HSPS_REG_STAT, 32'h0, s);
    chk("stat_reset", {32'h0, s}, 64'h0);
    av(1'b0, 6'h3c, 32'h0, s);
    chk("unmapped", {32'h0, s}, 64'h0);
    // All four strobe modes, each chosen by strap and host mode
    for (int m = 0; m < 4; m++) begin
      a = 64'h1122334455667788 + 64'(m);
      dev_reset({2'b01, m[1:0]});
      wr(`HSPS_REG_MODE, {30'h0, m[1:0]});
      op(OWN_ID, 4'h3, 8'hff, a, 3'b001, 8'h1, d);
      peek(4'h3, a);
      op(OWN_ID, 4'h3, 8'h0f, ~a, 3'b001, 8'h1, d);
      peek(4'h3, {a[63:32], ~a[31:0]});
      op(OWN_ID, 4'h3, 8'hff, 64'h0, 3'b011, 8'h1, d);
      chk("read_word", d, {a[63:32], ~a[31:0]});
      op(4'ha, 4'h5, 8'hff, ~a, 3'b101, 8'h1, d);
      peek(4'h5, ~a);
      if (m[0]) begin
        op(OWN_ID, 4'h9, 8'hff, a, 3'b001, 8'h1, d);
        op(OWN_ID, 4'h8, 8'hff, ~a, 3'b001, 8'h2, d);
        peek(4'h9, ~a);
      end
    end
    dev_reset(4'b1101);
    for (int k = 0; k < 4; k++) begin
      wr(`HSPS_REG_MODE, {28'h0, k[1:0], 2'b01});
      op(OWN_ID, 4'h2, 8'hff, LANES, 3'b001, 8'h1, d);
      peek(4'h2, swap(LANES, k[1:0]));
    end
    dev_reset(4'b0001);
    wr(`HSPS_REG_MODE, 32'h1);
    op(OWN_ID, 4'h4, 8'hff, a, 3'b001, 8'h1, d);
    peek(4'h4, {32'h0, a[31:0]});
    op(OWN_ID, 4'h4, 8'hff, 64'h0, 3'b011, 8'h1, d);
    chk("narrow_low", {32'h0, d[31:0]}, {32'h0, a[31:0]});
    // Foreign identity never answers; host reset is the only way out
    wr(`HSPS_REG_TGT, 32'ha);
    wr(`HSPS_REG_CTRL, 32'h1);
    repeat (300) @(posedge sys_clk);
    av(1'b0, `HSPS_REG_STAT, 32'h0, s);
    chk("stat_stuck", {32'h0, s}, 64'h1);
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    av(1'b0, `HSPS_REG_STAT, 32'h0, s);
    chk("stat_after_reset", {32'h0, s}, 64'h0);
    finish_test();
  end
endmodule
`default_nettype wire
